// ---- rtl/tmr_map.vh ----
// Register offsets, field positions and reset values of the 16-bit timer.
// Included by the timer design files; definitions only.
`ifndef TMR_MAP_VH
`define TMR_MAP_VH

// Byte offsets on the APB register bus
`define TMR_OFS_MODE        8'h00
`define TMR_OFS_CCCTL       8'h04
`define TMR_OFS_OUTCTL      8'h08
`define TMR_OFS_EDGEMODE    8'h0C
`define TMR_OFS_SAMPLE      8'h10
`define TMR_OFS_PRESCALE    8'h14
`define TMR_OFS_COUNT       8'h18
`define TMR_OFS_CMPA        8'h1C
`define TMR_OFS_CMPB        8'h20
`define TMR_OFS_STATUS      8'h24
`define TMR_OFS_MASK        8'h28

// Mode control: operating mode in bits 3..1
`define TMR_MODE_LSB        1
`define TMR_MODE_MSB        3
`define TMR_MODE_STOP       3'h0
`define TMR_MODE_CLRMATCH   3'h6

// Capture/compare control
`define TMR_CC_CAPTURE      0
`define TMR_CC_EXTCOUNT     1

// Output control
`define TMR_OC_ENABLE       0
`define TMR_OC_TOGGLE       1
`define TMR_OC_ONESHOT      4
`define TMR_OC_EXTTRIG      5
`define TMR_OC_SOFTTRIG     6

// Edge select in bits 3..2
`define TMR_ES_LSB          2
`define TMR_ES_MSB          3
`define TMR_ES_FALL         2'h0
`define TMR_ES_RISE         2'h1
`define TMR_ES_BOTH         2'h3

// Status and mask bit positions
`define TMR_ST_MATCHA       0
`define TMR_ST_MATCHB       1
`define TMR_ST_EDGE         2
`define TMR_ST_OVF          3

// Reset values and counter maximum
`define TMR_RST_8           8'h00
`define TMR_RST_16          16'h0000
`define TMR_RST_CMPA        16'hFFFF
`define TMR_CNT_MAX         16'hFFFF

`endif

// ---- rtl/tmr_edge_detect.v ----
// Trigger input filter: samples the pin at a programmable interval,
// accepts a level after two equal samples, reports the selected edges.
// Assumes the pin is already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.vh"

module tmr_edge_detect
(
  input  wire       clk,
  input  wire       nrst,
  input  wire       pinIn,
  input  wire [3:0] sampleSel,
  input  wire [1:0] edgeSel,
  output reg        edgePulse
);

  reg  [3:0] sampleCnt_reg;
  reg        sampA_reg;
  reg        level_reg;
  wire       sampleTick;
  wire       levelNew;
  wire       rise;
  wire       fall;

  assign sampleTick = (sampleCnt_reg == sampleSel);
  assign levelNew   = sampleTick && (sampA_reg == pinIn) && (sampA_reg != level_reg);
  assign rise       = levelNew && pinIn;
  assign fall       = levelNew && !pinIn;

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      sampleCnt_reg <= 4'h0;
      sampA_reg     <= 1'b0;
      level_reg     <= 1'b0;
      edgePulse     <= 1'b0;
    end
    else
    begin
      sampleCnt_reg <= sampleTick ? 4'h0 : sampleCnt_reg + 4'h1;
      if (sampleTick)
        sampA_reg <= pinIn;
      if (levelNew)
        level_reg <= pinIn;
      case (edgeSel)
        `TMR_ES_FALL: edgePulse <= fall;
        `TMR_ES_RISE: edgePulse <= rise;
        `TMR_ES_BOTH: edgePulse <= rise | fall;
        default:      edgePulse <= 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- rtl/tmr_timer16.v ----
// 16-bit timer/event counter with compare, capture, one-shot pulse,
// overflow flag and an APB register slave with masked interrupt.
// Assumes one clock, synchronous active-low reset, synchronous pins.
//
// Notes on behaviour
// - Nonzero mode field starts counting; zero stops
// - Free prescaler: first match may shift one tick
// - Compare A below count: wrap, then match
// - Capture skipped while compare B being read
// - Edge flag set even when capture skipped
// - Edge select in bits 2 and 3
// - External triggers ignored during a pulse
// - Overflow flag on FFFF to 0000 step
// - Trigger clears counter; B sets, A clears output
// - Rising, falling or both edges selectable
// - Bit 6 write issues software trigger
// - Edge valid after two equal samples
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.vh"

module tmr_timer16
#(
  parameter ADDR_W = 8
)
(
  input  wire              clk,
  input  wire              nrst,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output reg               pslverr,
  input  wire              trigger_input_pin,
  output reg               pulse_output_pin,
  output wire              irq
);

  ////////////////////////////////////////////////////////////////////
  // Registers
  reg  [2:0]  opMode_reg;
  reg  [1:0]  ccCtl_reg;
  reg  [5:0]  outCtl_reg;
  reg  [1:0]  edgeSel_reg;
  reg  [3:0]  sampleSel_reg;
  reg  [7:0]  prescale_reg;
  reg  [15:0] count_reg;
  reg  [15:0] cmpA_reg;
  reg  [15:0] cmpB_reg;
  reg  [3:0]  status_reg;
  reg  [3:0]  mask_reg;
  reg  [7:0]  preCnt_reg;
  reg         pulseActive_reg;
  reg         outLevel_reg;

  reg  [15:0] count_next;
  reg  [3:0]  status_next;
  reg         pulseActive_next;
  reg         outLevel_next;

  wire        edgeValid;
  wire        running;
  wire        wrAcc;
  wire        rdSel;
  wire        cmpBRead;
  wire        preTick;
  wire        countPulse;
  wire        clrOnMatch;
  wire        matchA;
  wire        matchB;
  wire        ovfStep;
  wire        softTrig;
  wire        extTrig;
  wire        trig;
  wire        capture;
  wire [7:0]  addr8;
  wire        mapped;
  wire [3:0]  setBits;
  wire [3:0]  clrBits;

  ////////////////////////////////////////////////////////////////////
  // Trigger input filter
  tmr_edge_detect u_edge
  (
    .clk       (clk),
    .nrst      (nrst),
    .pinIn     (trigger_input_pin),
    .sampleSel (sampleSel_reg),
    .edgeSel   (edgeSel_reg),
    .edgePulse (edgeValid)
  );

  ////////////////////////////////////////////////////////////////////
  // Bus decode
  assign addr8    = paddr[7:0];
  assign pready   = 1'b1;
  assign wrAcc    = psel && penable && pwrite;
  assign rdSel    = psel && !pwrite;
  assign cmpBRead = rdSel && (addr8 == `TMR_OFS_CMPB);
  assign mapped   = (addr8 == `TMR_OFS_MODE) || (addr8 == `TMR_OFS_CCCTL) ||
                    (addr8 == `TMR_OFS_OUTCTL) || (addr8 == `TMR_OFS_EDGEMODE) ||
                    (addr8 == `TMR_OFS_SAMPLE) || (addr8 == `TMR_OFS_PRESCALE) ||
                    (addr8 == `TMR_OFS_COUNT) || (addr8 == `TMR_OFS_CMPA) ||
                    (addr8 == `TMR_OFS_CMPB) || (addr8 == `TMR_OFS_STATUS) ||
                    (addr8 == `TMR_OFS_MASK);

  ////////////////////////////////////////////////////////////////////
  // Counting
  assign running    = (opMode_reg != `TMR_MODE_STOP);
  // Prescaler never restarts, so start is not aligned to a tick
  assign preTick    = (preCnt_reg == prescale_reg);
  assign countPulse = running && (ccCtl_reg[`TMR_CC_EXTCOUNT] ? edgeValid : preTick);
  assign clrOnMatch = (opMode_reg == `TMR_MODE_CLRMATCH);
  assign matchA     = countPulse && (count_reg == cmpA_reg);
  assign matchB     = countPulse && !ccCtl_reg[`TMR_CC_CAPTURE] && (count_reg == cmpB_reg);
  assign ovfStep    = countPulse && (count_reg == `TMR_CNT_MAX);
  assign softTrig   = wrAcc && (addr8 == `TMR_OFS_OUTCTL) &&
                      pwdata[`TMR_OC_SOFTTRIG] && outCtl_reg[`TMR_OC_ONESHOT];
  assign extTrig    = edgeValid && outCtl_reg[`TMR_OC_EXTTRIG] && !pulseActive_reg;
  assign trig       = running && (softTrig || extTrig);
  assign capture    = running && edgeValid && ccCtl_reg[`TMR_CC_CAPTURE] && !cmpBRead;

  always @*
  begin
    count_next = count_reg;
    if (!running)
      count_next = `TMR_RST_16;
    else if (trig)
      count_next = `TMR_RST_16;
    else if (countPulse)
    begin
      if (clrOnMatch && matchA)
        count_next = `TMR_RST_16;
      else
        count_next = count_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pulse output
  always @*
  begin
    pulseActive_next = pulseActive_reg;
    outLevel_next    = outLevel_reg;
    if (!running)
      pulseActive_next = 1'b0;
    else if (trig)
    begin
      pulseActive_next = 1'b1;
      outLevel_next    = 1'b0;
    end
    else if (pulseActive_reg)
    begin
      if (matchA)
      begin
        outLevel_next    = 1'b0;
        pulseActive_next = 1'b0;
      end
      else if (matchB)
        outLevel_next = 1'b1;
    end
    else if (matchA && outCtl_reg[`TMR_OC_TOGGLE])
      outLevel_next = !outLevel_reg;
  end

  ////////////////////////////////////////////////////////////////////
  // Status flags: a set in the same cycle beats the clear
  assign setBits = {ovfStep, edgeValid, matchB, matchA};
  assign clrBits = (wrAcc && (addr8 == `TMR_OFS_STATUS)) ? pwdata[3:0] : 4'h0;
  assign irq     = |(status_reg & mask_reg);

  always @*
  begin
    status_next = (status_reg & ~clrBits) | setBits;
  end

  ////////////////////////////////////////////////////////////////////
  // Sequential state and register writes
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      opMode_reg       <= `TMR_MODE_STOP;
      ccCtl_reg        <= 2'h0;
      outCtl_reg       <= 6'h00;
      edgeSel_reg      <= `TMR_ES_FALL;
      sampleSel_reg    <= 4'h0;
      prescale_reg     <= `TMR_RST_8;
      count_reg        <= `TMR_RST_16;
      cmpA_reg         <= `TMR_RST_CMPA;
      cmpB_reg         <= `TMR_RST_16;
      status_reg       <= 4'h0;
      mask_reg         <= 4'h0;
      preCnt_reg       <= `TMR_RST_8;
      pulseActive_reg  <= 1'b0;
      outLevel_reg     <= 1'b0;
      pulse_output_pin <= 1'b0;
    end
    else
    begin
      preCnt_reg       <= preTick ? `TMR_RST_8 : preCnt_reg + 8'h01;
      count_reg        <= count_next;
      status_reg       <= status_next;
      pulseActive_reg  <= pulseActive_next;
      outLevel_reg     <= outLevel_next;
      pulse_output_pin <= outLevel_next && outCtl_reg[`TMR_OC_ENABLE];
      if (capture)
        cmpB_reg <= count_reg;
      if (wrAcc)
      begin
        case (addr8)
          `TMR_OFS_MODE:     opMode_reg    <= pwdata[`TMR_MODE_MSB:`TMR_MODE_LSB];
          `TMR_OFS_CCCTL:    ccCtl_reg     <= pwdata[1:0];
          `TMR_OFS_OUTCTL:   outCtl_reg    <= pwdata[5:0];
          `TMR_OFS_EDGEMODE: edgeSel_reg   <= pwdata[`TMR_ES_MSB:`TMR_ES_LSB];
          `TMR_OFS_SAMPLE:   sampleSel_reg <= pwdata[3:0];
          `TMR_OFS_PRESCALE: prescale_reg  <= pwdata[7:0];
          `TMR_OFS_CMPA:     cmpA_reg      <= pwdata[15:0];
          `TMR_OFS_CMPB:     cmpB_reg      <= pwdata[15:0];
          `TMR_OFS_MASK:     mask_reg      <= pwdata[3:0];
          default:           mask_reg      <= mask_reg;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data, latched in the setup cycle
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr <= !mapped;
      prdata  <= 32'h0000_0000;
      if (!pwrite)
      begin
        case (addr8)
          `TMR_OFS_MODE:     prdata <= {28'h000_0000, opMode_reg, 1'b0};
          `TMR_OFS_CCCTL:    prdata <= {30'h000_0000, ccCtl_reg};
          `TMR_OFS_OUTCTL:   prdata <= {26'h00_0000, outCtl_reg};
          `TMR_OFS_EDGEMODE: prdata <= {28'h000_0000, edgeSel_reg, 2'h0};
          `TMR_OFS_SAMPLE:   prdata <= {28'h000_0000, sampleSel_reg};
          `TMR_OFS_PRESCALE: prdata <= {24'h00_0000, prescale_reg};
          `TMR_OFS_COUNT:    prdata <= {16'h0000, count_reg};
          `TMR_OFS_CMPA:     prdata <= {16'h0000, cmpA_reg};
          `TMR_OFS_CMPB:     prdata <= {16'h0000, cmpB_reg};
          `TMR_OFS_STATUS:   prdata <= {28'h000_0000, status_reg};
          `TMR_OFS_MASK:     prdata <= {28'h000_0000, mask_reg};
          default:           prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- verif/tmr_timer16_props.sv ----
// Port checker of the timer: APB answers, errors, irq mask.
// Assumes word offsets above 0x28 are unmapped.
`timescale 1ns/1ps
`default_nettype none
module tmr_timer16_props
#(
  parameter ADDR_W = 8
)
(
  input wire              clk,
  input wire              nrst,
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0]       pwdata,
  input wire [31:0]       prdata,
  input wire              pready,
  input wire              pslverr,
  input wire              trigger_input_pin,
  input wire              pulse_output_pin,
  input wire              irq
);
  wire acc = psel && penable;
  wire bad = paddr[7:2] > 6'd10;
  wire stp = psel && !penable;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (acc && bad |-> pslverr)
    else $error("no error on unmapped");
  a_err_mapped: assert property (acc && !bad && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("error on mapped");
  a_bad_rdzero: assert property (acc && bad && !pwrite |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property ($past(nrst) && !$past(stp) |-> $stable(prdata))
    else $error("prdata moved");
  a_err_hold: assert property ($past(nrst) && !$past(stp) |-> $stable(pslverr))
    else $error("pslverr moved");
  a_reset_quiet: assert property ($rose(nrst) |-> !irq && !pulse_output_pin)
    else $error("outputs busy after reset");
  a_mask_off: assert property (acc && pwrite && paddr == 8'h28 && pwdata[3:0] == 4'h0 |=> !irq)
    else $error("irq with mask clear");
  c_err: cover property (acc && pslverr);
  c_irq: cover property ($rose(irq));
  c_pulse: cover property ($rose(pulse_output_pin));
endmodule
bind tmr_timer16 tmr_timer16_props #(.ADDR_W(ADDR_W)) u_props
  (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .trigger_input_pin(trigger_input_pin),
   .pulse_output_pin(pulse_output_pin), .irq(irq));
`default_nettype wire

// ---- verif/tmr_pin_model.sv ----
// Trigger source and output load of the timer.
// Assumes commands change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model
(
  input  wire        clk,
  input  wire        lvlCmd,
  input  wire        pulseIn,
  output logic       trigPin,
  output logic [7:0] highCnt
);
  initial trigPin = 1'b0;
  initial highCnt = 8'h00;
  // Load counts cycles spent high
  always @(posedge clk)
  begin
    trigPin <= lvlCmd;
    highCnt <= highCnt + {7'h00, pulseIn};
  end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// Bench of the timer: APB tasks, pin model, scenarios.
// Assumes a zero-wait APB slave.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.vh"
module tb;
  logic        clk, nrst, psel, penable, pwrite, lvl, rerr;
  logic [7:0]  paddr, h0;
  logic [31:0] pwdata, rdat;
  wire  [31:0] prdata;
  wire         pready, pslverr, trig, pout, irq;
  wire  [7:0]  hc;
  logic [1:0]  es [3] = '{`TMR_ES_FALL, `TMR_ES_RISE, `TMR_ES_BOTH};
  int          n_errors, checks_done, i;
  tmr_timer16 u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger_input_pin(trig),
    .pulse_output_pin(pout), .irq(irq));
  tmr_pin_model u_pin (.clk(clk), .lvlCmd(lvl), .pulseIn(pout), .trigPin(trig),
    .highCnt(hc));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic last);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    if (last)
    begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0000_0000, 1'b1);
  endtask
  task automatic tg(input logic v, input int n);
    lvl <= v;
    cyc(n);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #(90000 * 50);
    n_errors++;
    end_of_test;
  end
  initial
  begin
    {nrst, psel, penable, pwrite, lvl} = 5'b00000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    n_errors = 0;
    checks_done = 0;
    cyc(8);
    nrst <= 1'b1;
    cyc(1);
    for (i = 0; i < 12; i++)
    begin
      rd(8'(i * 4));
      chk("reset", (i == 7) ? 32'h0000_FFFF : 32'h0000_0000, rdat);
      chk("pslverr", {31'h0, i == 11}, {31'h0, rerr});
    end
    // Event counting, glitch then full pulse
    wr(`TMR_OFS_CCCTL, 32'h0000_0002);
    wr(`TMR_OFS_CMPA, 32'h0000_0100);
    for (i = 0; i < 3; i++)
    begin
      wr(`TMR_OFS_MODE, 32'h0000_0000);
      wr(`TMR_OFS_EDGEMODE, {28'h0, es[i], 2'b00});
      wr(`TMR_OFS_MODE, 32'h0000_0002);
      tg(1'b1, 1);
      tg(1'b0, 4);
      tg(1'b1, 4);
      tg(1'b0, 6);
      rd(`TMR_OFS_COUNT);
      chk("edges", (i == 2) ? 32'h2 : 32'h1, rdat);
    end
    // Soft one-shot, second trigger only after match A
    wr(`TMR_OFS_CCCTL, 32'h0000_0000);
    wr(`TMR_OFS_MODE, 32'h0000_0002);
    wr(`TMR_OFS_CMPB, 32'h0000_0002);
    wr(`TMR_OFS_CMPA, 32'h0000_0004);
    wr(`TMR_OFS_OUTCTL, 32'h0000_0011);
    for (i = 0; i < 2; i++)
    begin
      wr(`TMR_OFS_STATUS, 32'h0000_000F);
      h0 = hc;
      wr(`TMR_OFS_OUTCTL, 32'h0000_0051);
      cyc(8);
      chk("soft_width", 32'h2, {24'h0, hc - h0});
      rd(`TMR_OFS_STATUS);
      chk("match_a", 32'h1, rdat & 32'h1);
    end
    // External one-shot, retrigger in mid-pulse
    wr(`TMR_OFS_MODE, 32'h0000_0000);
    wr(`TMR_OFS_EDGEMODE, 32'h0000_0004);
    wr(`TMR_OFS_CMPB, 32'h0000_000A);
    wr(`TMR_OFS_CMPA, 32'h0000_0028);
    wr(`TMR_OFS_OUTCTL, 32'h0000_0021);
    wr(`TMR_OFS_MODE, 32'h0000_0002);
    h0 = hc;
    tg(1'b1, 20);
    tg(1'b0, 4);
    tg(1'b1, 40);
    chk("ext_width", 32'h1E, {24'h0, hc - h0});
    tg(1'b0, 6);
    // Capture skipped during back-to-back reads
    wr(`TMR_OFS_OUTCTL, 32'h0000_0000);
    wr(`TMR_OFS_MODE, 32'h0000_0000);
    wr(`TMR_OFS_CMPB, 32'h0000_1234);
    wr(`TMR_OFS_CCCTL, 32'h0000_0001);
    wr(`TMR_OFS_MODE, 32'h0000_0002);
    wr(`TMR_OFS_STATUS, 32'h0000_000F);
    lvl <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      xfer(1'b0, `TMR_OFS_CMPB, 32'h0000_0000, i == 7);
      chk("cap_kept", 32'h1234, rdat);
    end
    rd(`TMR_OFS_STATUS);
    chk("edge_flag", 32'h4, rdat & 32'h4);
    wr(`TMR_OFS_MASK, 32'h0000_0004);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(`TMR_OFS_MASK, 32'h0000_0000);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(`TMR_OFS_MASK, 32'h0000_0004);
    wr(`TMR_OFS_STATUS, 32'h0000_0004);
    chk("irq_clr", 32'h0, {31'h0, irq});
    tg(1'b0, 6);
    tg(1'b1, 6);
    rd(`TMR_OFS_CMPB);
    chk("cap_new", 32'h1, {31'h0, rdat != 32'h1234});
    // Compare A lowered below count
    wr(`TMR_OFS_CCCTL, 32'h0000_0000);
    wr(`TMR_OFS_CMPA, 32'h0000_0200);
    wr(`TMR_OFS_MODE, 32'h0000_000C);
    cyc(300);
    wr(`TMR_OFS_CMPA, 32'h0000_0080);
    wr(`TMR_OFS_STATUS, 32'h0000_000F);
    cyc(400);
    rd(`TMR_OFS_STATUS);
    chk("no_early_match", 32'h0, rdat & 32'h1);
    wr(`TMR_OFS_MODE, 32'h0000_0000);
    wr(`TMR_OFS_MODE, 32'h0000_000C);
    wr(`TMR_OFS_STATUS, 32'h0000_000F);
    cyc(200);
    rd(`TMR_OFS_STATUS);
    chk("restart_match", 32'h1, rdat & 32'h1);
    // Overflow at FFFF to 0000
    wr(`TMR_OFS_CMPA, 32'h0000_FFFF);
    wr(`TMR_OFS_MODE, 32'h0000_0000);
    wr(`TMR_OFS_MODE, 32'h0000_000C);
    wr(`TMR_OFS_STATUS, 32'h0000_000F);
    wr(`TMR_OFS_MASK, 32'h0000_0008);
    cyc(65000);
    rd(`TMR_OFS_STATUS);
    chk("ovf_early", 32'h0, rdat & 32'h8);
    cyc(600);
    rd(`TMR_OFS_STATUS);
    chk("ovf", 32'h8, rdat & 32'h8);
    chk("irq_ovf", 32'h1, {31'h0, irq});
    end_of_test;
  end
endmodule
`default_nettype wire
